// [core/smf_mmu_firewall.v]
// Purpose: Segment MMU and contactless-OS mode firewall.
// Assumes: Requests synchronous to sys_clk; table loaded by a table walker
//          outside, through the table write port, at the address it derives
//          from table_base.
// Notes:   One registered answer per accepted request.
// Operation
// - Five CPU modes; each access is checked under exactly one mode.
// - Mode comes from program status high plus two hidden internal bits and the contactless-OS flag set by vectored calls.
// - Each of 64 segments holds rights, first/last address and relocation.
// - Each segment says if it may touch hardware-component registers.
// - A segment without any right is disabled and matches nothing.
// - Any count of defined segments from zero to 64 works.
// - Segment table location comes from a segmentation pointer register.
// - Firewall control and window base/size govern contactless-OS access.
// - Contactless-OS mode reaches hardware registers only if firewall permits.
// - With the mode suppressed, vectored calls act as plain indirect calls.
// - Without the mode, firewall registers stay but have no effect.
// - Memory read/write/execute and register read/write are all checked.
// - Without the mode, 128 NVM bytes are reserved; whole RAM open.
// - ROM test/app split; NVM and RAM split into OS and app regions.
// - User and system memory addresses are virtual and translated; boot, test and contactless-OS pass them untranslated.
// - Every memory access is checked before it is performed.
`timescale 1ns/1ps
`include "smf_consts.vh"

module smf_mmu_firewall #(
    parameter AW       = 16,
    parameter NSEG     = `SMF_NUM_SEG,
    parameter CLOS_EN  = 1,
    parameter ROM_TEST_END   = 16'h0fff,
    parameter NVM_BASE       = 16'h8000,
    parameter NVM_CLOS_END   = 16'h87ff,
    parameter RAM_BASE       = 16'he000,
    parameter RAM_CLOS_END   = 16'he3ff
) (
    // Clock and reset
    input  wire          sys_clk,
    input  wire          nrst,
    input  wire          clk_en,
    // Mode state
    input  wire [7:0]    program_status_high,
    input  wire [1:0]    mode_hidden,
    input  wire          vectored_mode_call,
    input  wire          mode_return,
    // Configuration registers
    input  wire [15:0]   table_base,
    input  wire [7:0]    firewall_control_low,
    input  wire [7:0]    firewall_control_high,
    input  wire [7:0]    exchange_window_base_low,
    input  wire [7:0]    exchange_window_base_high,
    input  wire [7:0]    exchange_window_size_low,
    input  wire [7:0]    exchange_window_size_high,
    // Table load port
    input  wire          tbl_we,
    input  wire [5:0]    tbl_idx,
    input  wire [63:0]   tbl_data,
    // Access request
    input  wire          req,
    input  wire [1:0]    req_op,
    input  wire          req_sfr,
    input  wire          req_hw_sfr,
    input  wire [AW-1:0] req_addr,
    // Access answer
    output reg           grant,
    output reg           violation,
    output reg  [AW-1:0] phys_addr,
    output reg  [2:0]    cpu_mode,
    output wire [15:0]   table_ptr,
    output reg           clos_active
);
    // ----------------------------------------------------------------
    // Segment table storage
    // ----------------------------------------------------------------
    reg [63:0]   seg_tab [0:NSEG-1];
    wire [NSEG-1:0] hit_v;
    wire [NSEG-1:0] allow_v;
    wire [NSEG-1:0] hw_v;
    wire [AW-1:0]   pa_v [0:NSEG-1];
    integer k;

    assign table_ptr = table_base;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (k = 0; k < NSEG; k = k + 1) begin
                seg_tab[k] <= 64'h0;
            end
        end else if (clk_en && tbl_we) begin
            seg_tab[tbl_idx] <= tbl_data;
        end
    end

    // ----------------------------------------------------------------
    // Segment compare
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NSEG; g = g + 1) begin : seg
            smf_seg_match #(.AW(AW)) u_match (
                .entry     (seg_tab[g]),
                .vaddr     (req_addr),
                .op        (req_op),
                .hit       (hit_v[g]),
                .allow     (allow_v[g]),
                .hw_sfr_ok (hw_v[g]),
                .paddr     (pa_v[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Mode derivation
    // ----------------------------------------------------------------
    reg       clos_flag;
    reg [2:0] mode_now;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            clos_flag <= 1'b0;
        end else if (clk_en) begin
            if (vectored_mode_call && CLOS_EN != 0) begin
                clos_flag <= 1'b1;
            end else if (mode_return) begin
                clos_flag <= 1'b0;
            end
        end
    end

    always @* begin
        if (mode_hidden == 2'h1) begin
            mode_now = `SMF_MODE_BOOT;
        end else if (mode_hidden == 2'h2) begin
            mode_now = `SMF_MODE_TEST;
        end else if (clos_flag) begin
            mode_now = `SMF_MODE_CLOS;
        end else if (program_status_high[`SMF_PSH_SYS]) begin
            mode_now = `SMF_MODE_SYSTEM;
        end else begin
            mode_now = `SMF_MODE_USER;
        end
    end

    // ----------------------------------------------------------------
    // Firewall and region checks
    // ----------------------------------------------------------------
    wire [15:0] win_base = {exchange_window_base_high, exchange_window_base_low};
    wire [15:0] win_size = {exchange_window_size_high, exchange_window_size_low};
    wire [16:0] win_end  = {1'b0, win_base} + {1'b0, win_size};
    wire        fw_hw_en = firewall_control_low[`SMF_FW_HWSFR_EN];
    wire        fw_live  = (CLOS_EN != 0);
    wire        is_clos  = (mode_now == `SMF_MODE_CLOS);
    wire        priv     = (mode_now == `SMF_MODE_BOOT) || (mode_now == `SMF_MODE_TEST);

    // ----------------------------------------------------------------
    // Region decode
    // ----------------------------------------------------------------
    wire [15:0] a16      = req_addr;
    wire        in_win   = ({1'b0, a16} >= {1'b0, win_base}) && ({1'b0, a16} < win_end);
    wire        in_rom_t = (a16 <= ROM_TEST_END);
    wire        in_nvm_c = (a16 >= NVM_BASE) &&
                           (a16 <= ((CLOS_EN != 0) ? NVM_CLOS_END
                                    : NVM_BASE + `SMF_MFR_NVM_SIZE - 16'h0001));
    wire        in_ram_c = (CLOS_EN != 0) && (a16 >= RAM_BASE) && (a16 <= RAM_CLOS_END);

    // ----------------------------------------------------------------
    // Access decision
    // ----------------------------------------------------------------
    reg         ok;
    reg [AW-1:0] pa;
    reg         any_hit;
    integer     i;

    always @* begin
        ok      = 1'b0;
        pa      = {AW{1'b0}};
        any_hit = 1'b0;
        for (i = NSEG - 1; i >= 0; i = i - 1) begin
            if (hit_v[i]) begin
                any_hit = 1'b1;
                ok      = req_sfr ? (!req_hw_sfr || hw_v[i]) : allow_v[i];
                pa      = pa_v[i];
            end
        end
        if (req_sfr) begin
            pa = req_addr;
            if (priv || mode_now == `SMF_MODE_SYSTEM) begin
                ok = 1'b1;
            end else if (is_clos && fw_live) begin
                ok = !req_hw_sfr || fw_hw_en || firewall_control_high[0];
            end else if (!any_hit) begin
                ok = !req_hw_sfr;
            end
        end else if (priv) begin
            ok = 1'b1;
            pa = req_addr;
        end else if (is_clos && fw_live) begin
            ok = (in_nvm_c || in_ram_c || in_win) && !in_rom_t;
            pa = req_addr;
        end else begin
            if (in_rom_t || in_nvm_c || in_ram_c) begin
                ok = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registered answer
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            grant       <= 1'b0;
            violation   <= 1'b0;
            phys_addr   <= {AW{1'b0}};
            cpu_mode    <= `SMF_MODE_BOOT;
            clos_active <= 1'b0;
        end else if (clk_en) begin
            cpu_mode    <= mode_now;
            clos_active <= clos_flag;
            grant       <= req && ok;
            violation   <= req && !ok;
            phys_addr   <= (req && ok) ? pa : {AW{1'b0}};
        end
    end
endmodule // smf_mmu_firewall

// [core/smf_consts.vh]
// Purpose: Constants for the segment MMU and mode firewall.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef SMF_CONSTS_VH
`define SMF_CONSTS_VH

// ----------------------------------------------------------------
// CPU modes
// ----------------------------------------------------------------
`define SMF_MODE_BOOT    3'h0
`define SMF_MODE_TEST    3'h1
`define SMF_MODE_CLOS    3'h2
`define SMF_MODE_SYSTEM  3'h3
`define SMF_MODE_USER    3'h4

// ----------------------------------------------------------------
// Access kinds
// ----------------------------------------------------------------
`define SMF_OP_READ      2'h0
`define SMF_OP_WRITE     2'h1
`define SMF_OP_EXEC      2'h2

// ----------------------------------------------------------------
// Segment entry field positions (64-bit entry)
// ----------------------------------------------------------------
`define SMF_ENT_R        0
`define SMF_ENT_W        1
`define SMF_ENT_X        2
`define SMF_ENT_HWSFR    3
`define SMF_ENT_FIRST_LO 16
`define SMF_ENT_FIRST_HI 31
`define SMF_ENT_LAST_LO  32
`define SMF_ENT_LAST_HI  47
`define SMF_ENT_REL_LO   48
`define SMF_ENT_REL_HI   63

// ----------------------------------------------------------------
// Program status high fields and firewall control fields
// ----------------------------------------------------------------
`define SMF_PSH_SYS      7
`define SMF_FW_HWSFR_EN  0

// ----------------------------------------------------------------
// Configuration and reset values
// ----------------------------------------------------------------
`define SMF_NUM_SEG      64
`define SMF_MFR_NVM_SIZE 16'h0080
`define SMF_RST_WORD     16'h0000

`endif

// [core/smf_seg_match.v]
// Purpose: One segment table entry compare and relocation.
// Assumes: Entry layout as in smf_consts.vh.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`include "smf_consts.vh"

module smf_seg_match #(
    parameter AW = 16
) (
    // Entry and request
    input  wire [63:0]   entry,
    input  wire [AW-1:0] vaddr,
    input  wire [1:0]    op,
    // Result
    output wire          hit,
    output wire          allow,
    output wire          hw_sfr_ok,
    output wire [AW-1:0] paddr
);
    wire          r_ok  = entry[`SMF_ENT_R];
    wire          w_ok  = entry[`SMF_ENT_W];
    wire          x_ok  = entry[`SMF_ENT_X];
    wire [AW-1:0] first = entry[`SMF_ENT_FIRST_LO +: AW];
    wire [AW-1:0] last  = entry[`SMF_ENT_LAST_LO +: AW];
    wire [AW-1:0] reloc = entry[`SMF_ENT_REL_LO +: AW];
    wire          live  = r_ok | w_ok | x_ok;

    assign hit       = live && (vaddr >= first) && (vaddr <= last);
    assign allow     = (op == `SMF_OP_READ)  ? r_ok :
                       (op == `SMF_OP_WRITE) ? w_ok :
                       (op == `SMF_OP_EXEC)  ? x_ok : 1'b0;
    assign hw_sfr_ok = entry[`SMF_ENT_HWSFR];
    assign paddr     = vaddr + reloc;
endmodule // smf_seg_match

// [test/smf_checker.sv]
// Purpose: Port assertions for smf_mmu_firewall.
// Assumes: One clock domain with asynchronous reset nrst.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
module smf_checker #(parameter CLOS_EN = 1) (
    // Inputs of the block
    input wire        sys_clk,
    input wire        nrst,
    input wire        clk_en,
    input wire [1:0]  mode_hidden,
    input wire        vectored_mode_call,
    input wire        mode_return,
    input wire [15:0] table_base,
    input wire [7:0]  firewall_control_low,
    input wire [7:0]  firewall_control_high,
    input wire        req,
    input wire        req_sfr,
    input wire        req_hw_sfr,
    input wire [15:0] req_addr,
    // Outputs of the block
    input wire        grant,
    input wire        violation,
    input wire [15:0] phys_addr,
    input wire [2:0]  cpu_mode,
    input wire [15:0] table_ptr,
    input wire        clos_active
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence taken; clk_en && req; endsequence
    sequence boot_req;
        clk_en && mode_hidden == 2'h1 ##1 clk_en && req && mode_hidden == 2'h1;
    endsequence
    sequence vec_enter;
        clk_en && vectored_mode_call && !mode_return && mode_hidden == 2'h0 ##1 clk_en;
    endsequence
    one_answer_a: assert property (taken |=> grant ^ violation)
        else $error("no single answer");
    idle_quiet_a: assert property (clk_en && !req |=> !grant && !violation)
        else $error("answer without request");
    deny_zero_a: assert property (violation |-> !grant && phys_addr == 16'h0000)
        else $error("denied access leaks address");
    ptr_copy_a: assert property (table_ptr == table_base)
        else $error("table pointer differs");
    mode_legal_a: assert property (cpu_mode <= 3'h4)
        else $error("illegal mode code");
    boot_pass_a: assert property (boot_req |=> grant && phys_addr == $past(req_addr))
        else $error("boot access not passed");
    vec_call_a: assert property (vec_enter |=> clos_active == (CLOS_EN != 0))
        else $error("vectored call mode wrong");
    fw_block_a: assert property (taken ##0 req_sfr && req_hw_sfr && clos_active
        && cpu_mode == 3'h2 && mode_hidden == 2'h0 && !$past(mode_return)
        && !firewall_control_low[0] && !firewall_control_high[0] |=> violation)
        else $error("firewall let access pass");
endmodule // smf_checker
bind smf_mmu_firewall smf_checker #(.CLOS_EN(CLOS_EN)) smf_checker_inst (.*);

// [test/smf_cpu_model.sv]
// Purpose: CPU core side that issues accesses.
// Assumes: Answer stands half a cycle after the taking edge.
// Notes:   Released address shows its inverse.
`timescale 1ns/1ps
module smf_cpu_model (
    // Clock and answer
    input wire        sys_clk,
    input wire        grant,
    input wire [15:0] phys_addr,
    // Request
    output reg        req = 1'b0,
    output reg [1:0]  req_op = 2'h0,
    output reg        req_sfr = 1'b0,
    output reg        req_hw_sfr = 1'b0,
    output reg [15:0] req_addr = 16'h0000
);
    task access(input [1:0] o, input s, input h, input [15:0] ad,
                output ok, output [15:0] pa);
        begin
            @(negedge sys_clk);
            req = 1'b1;
            req_op = o;
            req_sfr = s;
            req_hw_sfr = h;
            req_addr = ad;
            @(negedge sys_clk);
            ok = grant;
            pa = phys_addr;
            req = 1'b0;
            req_addr = ~ad;
        end
    endtask
endmodule // smf_cpu_model

// [test/smf_mmu_firewall_test.sv]
// Purpose: Self-checking bench for smf_mmu_firewall.
// Assumes: CPU side driven by smf_cpu_model.
// Notes:   Second instance runs without the contactless-OS mode.
`timescale 1ns/1ps
`include "smf_consts.vh"
module smf_mmu_firewall_test;
    reg        sys_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, tbl_we = 1'b0;
    reg        vectored_mode_call = 1'b0, mode_return = 1'b0;
    reg [7:0]  program_status_high = 8'h00;
    reg [1:0]  mode_hidden = 2'h0;
    reg [15:0] table_base = 16'h0000;
    reg [7:0]  firewall_control_low = 8'h00, firewall_control_high = 8'h00;
    reg [7:0]  exchange_window_base_low = 8'h00, exchange_window_base_high = 8'hf0;
    reg [7:0]  exchange_window_size_low = 8'h10, exchange_window_size_high = 8'h00;
    reg [5:0]  tbl_idx = 6'h00;
    reg [63:0] tbl_data = 64'h0;
    wire       req, req_sfr, req_hw_sfr, grant, violation, clos_active, b_grant;
    wire [1:0] req_op;
    wire [15:0] req_addr, phys_addr, table_ptr;
    wire [2:0] cpu_mode, b_mode;
    integer    n_fail = 0, checks = 0, seed = 9890, i;
    reg        ok, want;
    reg [1:0]  op;
    reg [15:0] a, pa;
    smf_mmu_firewall smf_mmu_firewall_inst (.*);
    smf_mmu_firewall #(.CLOS_EN(0)) smf_mmu_firewall_inst_b (.*, .grant(b_grant),
        .violation(), .phys_addr(), .cpu_mode(b_mode), .table_ptr(), .clos_active());
    smf_cpu_model smf_cpu_model_inst (.*);
    initial forever #50 sys_clk = ~sys_clk;
    function ok_user(input [1:0] o, input [15:0] ad);
        ok_user = (o == `SMF_OP_READ) && (ad >= 16'h1000) && (ad <= 16'h1fff);
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task acc(input [1:0] o, input s, input h, input [15:0] ad, input e, input [15:0] ep);
        begin
            smf_cpu_model_inst.access(o, s, h, ad, ok, pa);
            chk({15'h0, ok}, {15'h0, e});
            if (!s) chk(pa, ep);
        end
    endtask
    task put(input [5:0] idx, input [63:0] d);
        begin
            @(negedge sys_clk);
            tbl_we = 1'b1;
            tbl_idx = idx;
            tbl_data = d;
            @(negedge sys_clk);
            tbl_we = 1'b0;
        end
    endtask
    task settle;
        repeat (2) @(negedge sys_clk);
    endtask
    task end_sim;
        begin
            $display("checks %0d n_fail %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail = n_fail + 1;
        end_sim;
    end
    initial begin
        table_base = $random(seed);
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        nrst = 1'b1;
        chk({13'h0, cpu_mode}, {13'h0, `SMF_MODE_BOOT});
        chk(table_ptr, table_base);
        for (i = 0; i < 8; i = i + 1) begin
            mode_hidden = i[0] ? 2'h2 : 2'h1;
            op = i % 3;
            a = $random(seed);
            acc(op, 1'b0, 1'b0, a, 1'b1, a);
        end
        mode_hidden = 2'h0;
        settle;
        chk({13'h0, cpu_mode}, {13'h0, `SMF_MODE_USER});
        acc(`SMF_OP_READ, 1'b0, 1'b0, 16'h2000, 1'b0, 16'h0000);
        put(6'h03, 64'h4000_1fff_1000_0008);
        put(6'h05, 64'h3000_1fff_1000_0001);
        for (i = 0; i < 14; i = i + 1) begin
            op = $random(seed);
            if (op == 2'h3) op = `SMF_OP_READ;
            a = $random(seed) & 32'h3fff;
            if (i < 2) a = 16'h0fff + i[15:0];
            else if (i < 4) a = 16'h1ffd + i[15:0];
            want = ok_user(op, a);
            acc(op, 1'b0, 1'b0, a, want, want ? a + 16'h3000 : 16'h0000);
        end
        program_status_high = 8'h80;
        settle;
        chk({13'h0, cpu_mode}, {13'h0, `SMF_MODE_SYSTEM});
        acc(`SMF_OP_WRITE, 1'b1, 1'b1, 16'h00a0, 1'b1, 16'h0000);
        program_status_high = 8'h00;
        vectored_mode_call = 1'b1;
        @(negedge sys_clk);
        vectored_mode_call = 1'b0;
        settle;
        chk({13'h0, cpu_mode}, {13'h0, `SMF_MODE_CLOS});
        chk({13'h0, b_mode}, {13'h0, `SMF_MODE_USER});
        acc(`SMF_OP_WRITE, 1'b1, 1'b1, 16'h00a0, 1'b0, 16'h0000);
        firewall_control_high = 8'h01;
        acc(`SMF_OP_READ, 1'b1, 1'b1, 16'h00a0, 1'b1, 16'h0000);
        acc(`SMF_OP_READ, 1'b0, 1'b0, 16'he010, 1'b1, 16'he010);
        acc(`SMF_OP_READ, 1'b0, 1'b0, 16'h9000, 1'b0, 16'h0000);
        acc(`SMF_OP_WRITE, 1'b0, 1'b0, 16'hf008, 1'b1, 16'hf008);
        mode_return = 1'b1;
        @(negedge sys_clk);
        mode_return = 1'b0;
        settle;
        chk({13'h0, cpu_mode}, {13'h0, `SMF_MODE_USER});
        clk_en = 1'b0;
        mode_hidden = 2'h1;
        vectored_mode_call = 1'b1;
        settle;
        chk({13'h0, cpu_mode}, {13'h0, `SMF_MODE_USER});
        mode_hidden = 2'h0;
        vectored_mode_call = 1'b0;
        clk_en = 1'b1;
        settle;
        chk({13'h0, cpu_mode}, {13'h0, `SMF_MODE_USER});
        put(6'h00, 64'h0000_ffff_0000_0007);
        acc(`SMF_OP_READ, 1'b0, 1'b0, 16'h8010, 1'b0, 16'h0000);
        chk({15'h0, b_grant}, 16'h0000);
        acc(`SMF_OP_READ, 1'b0, 1'b0, 16'h8080, 1'b0, 16'h0000);
        chk({15'h0, b_grant}, 16'h0001);
        acc(`SMF_OP_READ, 1'b0, 1'b0, 16'he010, 1'b0, 16'h0000);
        chk({15'h0, b_grant}, 16'h0001);
        end_sim;
    end
endmodule // smf_mmu_firewall_test
